// ---- rtl/sbst_regs.vh ----
`ifndef SBST_REGS_VH
`define SBST_REGS_VH

// ----------------------------------------------------------------
// tap state bit positions (one-hot vector)
// ----------------------------------------------------------------
`define SBST_S_TLR   0
`define SBST_S_RTI   1
`define SBST_S_SELDR 2
`define SBST_S_CAPDR 3
`define SBST_S_SHDR  4
`define SBST_S_EX1DR 5
`define SBST_S_PSDR  6
`define SBST_S_EX2DR 7
`define SBST_S_UPDR  8
`define SBST_S_SELIR 9
`define SBST_S_CAPIR 10
`define SBST_S_SHIR  11
`define SBST_S_EX1IR 12
`define SBST_S_PSIR  13
`define SBST_S_EX2IR 14
`define SBST_S_UPIR  15
`define SBST_NSTATES 16

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define SBST_IR_W       3
`define SBST_IR_EXTEST  3'h0
`define SBST_IR_IDCODE  3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_PRELOAD 3'h4
`define SBST_IR_BYPASS  3'h7
`define SBST_IR_CAPTURE 3'h1

// ----------------------------------------------------------------
// data registers
// ----------------------------------------------------------------
`define SBST_BSR_LEN    89
`define SBST_BSR_TRI    88
`define SBST_ID_W       32
`define SBST_ID_REV     3'h0
`define SBST_ID_DEPTH   5'h0B
`define SBST_ID_ARCH    6'h01
`define SBST_ID_WIDTH   6'h27
// maker code value is arbitrary
`define SBST_ID_MAKER   11'h2A5
`define SBST_ID_PRESENT 1'h1
`define SBST_SYNC_W     3

`endif

// ---- rtl/sbst_sync.v ----
`timescale 1ns/10ps
module sbst_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_clock,
  input  wire             i_sys_rst,
  // asynchronous input and its synchronised copy
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_q <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// ---- rtl/sbst_tap.v ----
`timescale 1ns/10ps
`include "sbst_regs.vh"
// Notes on behaviour
// - inputs on tck rise, outputs on fall, except the cell 89 preset and the ir return to idcode on entering test-logic-reset
// - tms steers state machine each rise
// - tdi enters msb, tdo shows lsb
// - tdo driven only in shift states
// - five tms-high rises reset the tap
// - power-up resets tap, tdo high-z
// - instruction selects exactly one register
// - three-bit ir, idcode after reset
// - capture-ir loads 01 into low bits
// - one-bit bypass captures zero
// - boundary register captures io ring
// - boundary register is 89 cells
// - id register captures fixed 32-bit code
// - decode extest idcode samplez preload codes
// - instruction becomes current at update-ir
// - samplez selects boundary, bus high-z
// - preload snapshots pins at capture-dr
// - update-dr latches shifted pattern
// - extest drives latched pattern out
// - cell 89 latch gates output bus
// - tristate latch preset high in reset
// - id code field layout
module sbst_tap (
  // clock and reset
  input  wire                     i_clock,
  input  wire                     i_sys_rst,
  // tap pins
  input  wire                     i_tck,
  input  wire                     i_tms,
  input  wire                     i_tdi,
  output reg                      o_tdo,
  output reg                      o_tdo_oe,
  // io ring
  input  wire [`SBST_BSR_LEN-1:0] i_ring,
  output reg  [`SBST_BSR_LEN-1:0] o_bsr_latch,
  output reg                      o_extest,
  output reg                      o_bus_hiz
);

  // ----------------------------------------------------------------
  // synchronisers and tck edge detection
  // ----------------------------------------------------------------
  wire [`SBST_SYNC_W-1:0]  pins_s;
  wire [`SBST_BSR_LEN-1:0] ring_s;
  wire                     tck_s;
  wire                     tms_s;
  wire                     tdi_s;
  reg                      tck_prev_q;
  wire                     rise;
  wire                     fall;

  sbst_sync #(.WIDTH(`SBST_SYNC_W)) u_pin_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_tck, i_tms, i_tdi}),
    .o_sync    (pins_s)
  );

  // ring values are sampled, a moving memory clock cell may read either level
  sbst_sync #(.WIDTH(`SBST_BSR_LEN)) u_ring_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_ring),
    .o_sync    (ring_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  assign rise  = tck_s & ~tck_prev_q;
  assign fall  = ~tck_s & tck_prev_q;

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  // ----------------------------------------------------------------
  // tap state machine
  // ----------------------------------------------------------------
  wire [`SBST_NSTATES-1:0] st;

  sbst_tap_fsm u_fsm (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_step    (rise),
    .i_tms     (tms_s),
    .o_state   (st)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  reg  [`SBST_IR_W-1:0] ir_q;
  reg  [`SBST_IR_W-1:0] ir_sh_q;
  wire                  is_extest;
  wire                  is_samplez;
  wire                  sel_bsr;
  wire                  sel_id;
  wire                  sel_byp;

  assign is_extest  = (ir_q == `SBST_IR_EXTEST);
  assign is_samplez = (ir_q == `SBST_IR_SAMPLEZ);
  assign sel_bsr    = is_extest | is_samplez |
                      (ir_q == `SBST_IR_PRELOAD);
  assign sel_id     = (ir_q == `SBST_IR_IDCODE);
  // anything else, reserved codes included, keeps the chain one bit long
  assign sel_byp    = ~sel_bsr & ~sel_id;

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  wire [`SBST_ID_W-1:0]    id_code;
  reg  [`SBST_ID_W-1:0]    id_sh_q;
  reg  [`SBST_BSR_LEN-1:0] bsr_sh_q;
  reg                      byp_q;
  reg                      tdo_bit;

  assign id_code = {`SBST_ID_REV, `SBST_ID_DEPTH, `SBST_ID_ARCH,
                    `SBST_ID_WIDTH, `SBST_ID_MAKER, `SBST_ID_PRESENT};

  always @* begin
    tdo_bit = byp_q;
    if (st[`SBST_S_SHIR]) begin
      tdo_bit = ir_sh_q[0];
    end else if (sel_bsr) begin
      tdo_bit = bsr_sh_q[0];
    end else if (sel_id) begin
      tdo_bit = id_sh_q[0];
    end
  end

  // ----------------------------------------------------------------
  // rising tck: capture and shift; falling tck: update and tdo
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ir_q        <= `SBST_IR_IDCODE;
      ir_sh_q     <= `SBST_IR_CAPTURE;
      id_sh_q     <= {`SBST_ID_W{1'b0}};
      bsr_sh_q    <= {`SBST_BSR_LEN{1'b0}};
      byp_q       <= 1'b0;
      o_bsr_latch <= {{(`SBST_BSR_LEN-1){1'b0}}, 1'b1} << `SBST_BSR_TRI;
      o_tdo       <= 1'b0;
      o_tdo_oe    <= 1'b0;
    end else begin
      if (st[`SBST_S_TLR]) begin
        ir_q <= `SBST_IR_IDCODE;
        o_bsr_latch[`SBST_BSR_TRI] <= 1'b1;
      end
      if (rise) begin
        if (st[`SBST_S_CAPIR]) begin
          ir_sh_q <= `SBST_IR_CAPTURE;
        end
        if (st[`SBST_S_SHIR]) begin
          ir_sh_q <= {tdi_s, ir_sh_q[`SBST_IR_W-1:1]};
        end
        if (st[`SBST_S_CAPDR]) begin
          if (sel_bsr) begin
            bsr_sh_q <= ring_s;
          end
          if (sel_id) begin
            id_sh_q <= id_code;
          end
          if (sel_byp) begin
            byp_q <= 1'b0;
          end
        end
        if (st[`SBST_S_SHDR]) begin
          if (sel_bsr) begin
            bsr_sh_q <= {tdi_s, bsr_sh_q[`SBST_BSR_LEN-1:1]};
          end
          if (sel_id) begin
            id_sh_q <= {tdi_s, id_sh_q[`SBST_ID_W-1:1]};
          end
          if (sel_byp) begin
            byp_q <= tdi_s;
          end
        end
      end
      if (fall) begin
        if (st[`SBST_S_UPIR]) begin
          ir_q <= ir_sh_q;
        end
        // latch takes both pattern and tristate cell in one pass
        if (st[`SBST_S_UPDR] && sel_bsr) begin
          o_bsr_latch <= bsr_sh_q;
        end
        o_tdo    <= tdo_bit;
        o_tdo_oe <= st[`SBST_S_SHDR] | st[`SBST_S_SHIR];
      end
    end
  end

  // ----------------------------------------------------------------
  // output bus control, one clock behind the instruction
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_extest  <= 1'b0;
      o_bus_hiz <= 1'b0;
    end else begin
      o_extest  <= is_extest;
      o_bus_hiz <= is_samplez |
                   (is_extest & ~o_bsr_latch[`SBST_BSR_TRI]);
    end
  end

endmodule

// ---- rtl/sbst_tap_fsm.v ----
`timescale 1ns/10ps
`include "sbst_regs.vh"
module sbst_tap_fsm (
  // clock and reset
  input  wire                     i_clock,
  input  wire                     i_sys_rst,
  // rising tck event and sampled tms
  input  wire                     i_step,
  input  wire                     i_tms,
  // one-hot state
  output reg  [`SBST_NSTATES-1:0] o_state
);

  localparam [15:0] S_TLR   = 16'h0001;
  localparam [15:0] S_RTI   = 16'h0002;
  localparam [15:0] S_SELDR = 16'h0004;
  localparam [15:0] S_CAPDR = 16'h0008;
  localparam [15:0] S_SHDR  = 16'h0010;
  localparam [15:0] S_EX1DR = 16'h0020;
  localparam [15:0] S_PSDR  = 16'h0040;
  localparam [15:0] S_EX2DR = 16'h0080;
  localparam [15:0] S_UPDR  = 16'h0100;
  localparam [15:0] S_SELIR = 16'h0200;
  localparam [15:0] S_CAPIR = 16'h0400;
  localparam [15:0] S_SHIR  = 16'h0800;
  localparam [15:0] S_EX1IR = 16'h1000;
  localparam [15:0] S_PSIR  = 16'h2000;
  localparam [15:0] S_EX2IR = 16'h4000;
  localparam [15:0] S_UPIR  = 16'h8000;

  reg [15:0] state_d;

  // ----------------------------------------------------------------
  // next state, five tms-high steps reach reset from anywhere
  // ----------------------------------------------------------------
  always @* begin
    state_d = S_TLR;
    case (o_state)
      S_TLR:   state_d = i_tms ? S_TLR   : S_RTI;
      S_RTI:   state_d = i_tms ? S_SELDR : S_RTI;
      S_SELDR: state_d = i_tms ? S_SELIR : S_CAPDR;
      S_CAPDR: state_d = i_tms ? S_EX1DR : S_SHDR;
      S_SHDR:  state_d = i_tms ? S_EX1DR : S_SHDR;
      S_EX1DR: state_d = i_tms ? S_UPDR  : S_PSDR;
      S_PSDR:  state_d = i_tms ? S_EX2DR : S_PSDR;
      S_EX2DR: state_d = i_tms ? S_UPDR  : S_SHDR;
      S_UPDR:  state_d = i_tms ? S_SELDR : S_RTI;
      S_SELIR: state_d = i_tms ? S_TLR   : S_CAPIR;
      S_CAPIR: state_d = i_tms ? S_EX1IR : S_SHIR;
      S_SHIR:  state_d = i_tms ? S_EX1IR : S_SHIR;
      S_EX1IR: state_d = i_tms ? S_UPIR  : S_PSIR;
      S_PSIR:  state_d = i_tms ? S_EX2IR : S_PSIR;
      S_EX2IR: state_d = i_tms ? S_UPIR  : S_SHIR;
      S_UPIR:  state_d = i_tms ? S_SELDR : S_RTI;
      default: state_d = S_TLR;
    endcase
  end

  // moves only on a rising tck
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_state <= S_TLR;
    end else if (i_step) begin
      o_state <= state_d;
    end
  end

endmodule

// ---- verif/sbst_jtag_ctl.sv ----
`timescale 1ns/10ps
module sbst_jtag_ctl (
  // tap pins toward the device
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input  wire  i_tdo,
  input  wire  i_tdo_oe
);
  // idle: tck parked low, tms and tdi at their pulled-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // tms and tdi move with the fall so they hold well around the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #200 o_tck = 1'b1;
    #150 tdo = i_tdo_oe ? i_tdo : 1'bz;
    #50 o_tck = 1'b0;
  endtask
  // from idle: one ir or dr pass, lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [88:0] din,
                      output logic [88:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    o_tdi = 1'b1;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule

// ---- verif/sbst_tap_asserts.sv ----
`timescale 1ns/10ps
`include "sbst_regs.vh"
module sbst_tap_asserts (
  // clock and reset
  input wire                     i_clock,
  input wire                     i_sys_rst,
  // tap pins
  input wire                     i_tck,
  input wire                     i_tms,
  input wire                     i_tdi,
  input wire                     o_tdo,
  input wire                     o_tdo_oe,
  // io ring
  input wire [`SBST_BSR_LEN-1:0] i_ring,
  input wire [`SBST_BSR_LEN-1:0] o_bsr_latch,
  input wire                     o_extest,
  input wire                     o_bus_hiz
);
  // ------------------------------------------------
  // tck edge tracking
  // ------------------------------------------------
  // cycles since a tck fall; saturates so long idle never wraps
  reg       tck_q;
  reg [3:0] fall_cnt_q;
  reg [2:0] ones_q;
  always @(posedge i_clock) begin
    tck_q <= i_tck;
    if (i_sys_rst) begin
      fall_cnt_q <= 4'hF;
      ones_q     <= 3'h0;
    end else begin
      if (tck_q && !i_tck) fall_cnt_q <= 4'h0;
      else if (fall_cnt_q != 4'hF) fall_cnt_q <= fall_cnt_q + 4'h1;
      if (!tck_q && i_tck) ones_q <= !i_tms ? 3'h0 : (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  property p_tdo_edge; $changed(o_tdo) |-> fall_cnt_q inside {[1:6]}; endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved off a tck fall");
  property p_oe_edge; $changed(o_tdo_oe) |-> fall_cnt_q inside {[1:6]}; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("tdo enable moved off a fall");
  property p_rst_state; $past(i_sys_rst) |-> !o_tdo_oe && o_bsr_latch[88] && !o_extest; endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
  property p_tms_reset; ones_q >= 3'h5 |-> ##[0:8] (o_bsr_latch[88] && !o_extest); endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("tms reset not taken");
  property p_latch_edge; $changed(o_bsr_latch[87:0]) |-> fall_cnt_q inside {[1:6]}; endproperty
  a_latch_edge: assert property (p_latch_edge) else $error("latch moved off a fall");
  // rise-driven ir change is only legal on entry to test-logic-reset
  property p_ir_edge; $changed(o_extest) |-> fall_cnt_q inside {[1:6]} || ones_q >= 3'h3; endproperty
  a_ir_edge: assert property (p_ir_edge) else $error("instruction changed early");
  property p_ext_hiz; (o_extest && !o_bsr_latch[88]) [*2] |-> o_bus_hiz; endproperty
  a_ext_hiz: assert property (p_ext_hiz) else $error("bus driven with cell low");
  property p_ext_drv; (o_extest && o_bsr_latch[88]) [*2] |-> !o_bus_hiz; endproperty
  a_ext_drv: assert property (p_ext_drv) else $error("bus high-z with cell high");
endmodule

// ---- verif/sbst_tap_tb_top.sv ----
`timescale 1ns/10ps
`include "sbst_regs.vh"
module sbst_tap_tb_top;
  // ------------------------------------------------
  // wiring
  // ------------------------------------------------
  localparam logic [31:0] ID_CODE = {`SBST_ID_REV, `SBST_ID_DEPTH, `SBST_ID_ARCH,
                                     `SBST_ID_WIDTH, `SBST_ID_MAKER, `SBST_ID_PRESENT};
  localparam logic [88:0] RING_A = 89'h1_23_4567_89AB_CDEF_0123_4567;
  localparam logic [88:0] PRE_LO = 89'h0_C3_5A5A_C3C3_A55A_3C3C_0FF0;
  localparam logic [88:0] PRE_HI = 89'h1_3C_A5A5_0F0F_5AA5_C3C3_F00F;
  logic        clock;
  logic        sys_rst;
  logic [88:0] ring;
  logic [88:0] d;
  wire         tck, tms, tdi, tdo, tdo_oe, extest, bus_hiz;
  wire  [88:0] latch;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  sbst_tap sbst_tap_inst (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ring(ring), .o_bsr_latch(latch),
    .o_extest(extest), .o_bus_hiz(bus_hiz));
  sbst_jtag_ctl sbst_jtag_ctl_inst (
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
  task automatic check(input logic [88:0] got, input logic [88:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    sbst_jtag_ctl_inst.scan(1'b1, 3, {86'h0, code}, d);
    check(d, 89'h1);
  endtask
  task automatic dr(input int n, input logic [88:0] din);
    sbst_jtag_ctl_inst.scan(1'b0, n, din, d);
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_id_read();
    dr(32, '1);
    check(d, ID_CODE);
  endtask
  task automatic t_power_up();
    check(tdo_oe, 1'b0);
    check(latch, {1'b1, 88'h0});
    sbst_jtag_ctl_inst.tap_reset();
    t_id_read();
  endtask
  task automatic t_bypass();
    logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      dr(4, 89'hB);
      check(d, 89'h6);
      check({extest, bus_hiz}, 2'h0);
    end
  endtask
  task automatic t_preload();
    @(posedge clock) ring <= RING_A;
    #7;
    load_ir(3'h4);
    dr(89, PRE_LO);
    check(d, RING_A);
    check(latch, PRE_LO);
    check({extest, bus_hiz}, 2'h0);
  endtask
  task automatic t_extest();
    load_ir(3'h0);
    check({extest, bus_hiz}, 2'h3);
    dr(89, PRE_HI);
    check(d, RING_A);
    check(latch, PRE_HI);
    check(bus_hiz, 1'b0);
  endtask
  task automatic t_samplez();
    load_ir(3'h2);
    check({extest, bus_hiz}, 2'h1);
    dr(89, PRE_HI);
    check(d, RING_A);
    check(bus_hiz, 1'b1);
  endtask
  task automatic t_tap_reset();
    load_ir(3'h4);
    dr(89, PRE_LO);
    load_ir(3'h0);
    check({extest, bus_hiz}, 2'h3);
    sbst_jtag_ctl_inst.tap_reset();
    check({latch[88], extest, bus_hiz}, 3'h4);
    t_id_read();
  endtask
  // ------------------------------------------------
  // clock, run and timeout
  // ------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // run about 7 ns off the clock edges so tck never races the sampler
  initial begin
    sys_rst = 1'b1;
    ring = '0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    #7;
    t_power_up();
    t_bypass();
    t_preload();
    t_extest();
    t_samplez();
    t_tap_reset();
    wrap_up();
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
endmodule
bind sbst_tap sbst_tap_asserts sbst_tap_asserts_inst (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_ring(i_ring), .o_bsr_latch(o_bsr_latch),
  .o_extest(o_extest), .o_bus_hiz(o_bus_hiz));
